// File: hw/fifo_cfg.svh
/*
 * Sizing and reset constants of the clocked 2048 x 9 FIFO.
 * Assumes it is included by bare name from the package and the FIFO module.
 */
`ifndef FIFO_CFG_SVH
`define FIFO_CFG_SVH

`define FIFO_DEPTH 2048
`define FIFO_WIDTH 9
`define FIFO_OFFSET_W 10
`define FIFO_OFFSET_DEFAULT 10'h100
`define FIFO_OFFSET_MAX 10'h3FF

`endif

// File: hw/fifo_pkg.sv
/*
 * Types shared by the FIFO design and its bench.
 * Assumes fifo_cfg.svh is on the include path.
 */
`include "fifo_cfg.svh"

package fifo_pkg;

	// Where the threshold programming window stands after reset.
	typedef enum logic [1:0] {
		PROG_OPEN = 2'b00,
		PROG_SECOND = 2'b01,
		PROG_CLOSED = 2'b10
	} prog_state_t;

	typedef logic [`FIFO_OFFSET_W-1:0] offset_t;

endpackage

// File: hw/dual_clock_fifo.sv
/*
 * A 2048 x 9 first-in first-out memory with full, empty, half and
 * programmable near-limit flags and three-state style data outputs.
 * Assumes the write and read strobe pins are synchronous to clk, each
 * high and low for at least one clk period, and that the far side
 * combines read_data_out with read_data_oe on the board wire.
 */
`include "fifo_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Unprogrammed thresholds X and Y are 256.
// - Near flag high when count <= X or >= 2048-Y.
// - Reset clears pointers and presets all flags.
// - Offset msb pin is bit 9 of offset.
// - Empty flag low exactly when nothing stored.
// - Full flag low exactly when 2048 words stored.
// - Half flag high at 1024 words or more.
// - Write strobe stores a word only when not full.
// - Output enable low floats the data outputs.
// - Offsets captured only before the first write.
// - Read strobe advances only when not empty.
// - First program edge loads both X and Y.
// - Second program edge reloads only Y.
// - No data stored on programming edges.
// - Full memory leaves stored data untouched.
// - First word falls through to the outputs.
// - Output enable never touches the flags.
module dual_clock_fifo #(
	parameter int DEPTH = `FIFO_DEPTH,
	parameter int WIDTH = `FIFO_WIDTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic write_clock,
	input wire logic read_clock,
	input wire logic [WIDTH-1:0] write_data_in,
	input wire logic offset_msb_input,
	input wire logic threshold_program_enable_n,
	input wire logic output_enable,
	input wire logic chain_mode_select,
	input wire logic chain_head_select,
	input wire logic chain_token_in,
	output logic chain_token_out,
	output logic [WIDTH-1:0] read_data_out,
	output logic read_data_oe,
	output logic full_n,
	output logic empty_n,
	output logic half_level_flag,
	output logic near_limit_flag
);

	localparam int AW = $clog2(DEPTH);
	localparam int PW = AW + 1;
	localparam logic [PW-1:0] DEPTH_C = PW'(DEPTH);
	localparam logic [PW-1:0] HALF_C = PW'(DEPTH / 2);

	// The offset bus is the data bus plus one bit, and the largest offset
	// must stay below the depth, so other sizes are refused here.
	if (DEPTH < 4 || (1 << AW) != DEPTH || WIDTH < 1 ||
		DEPTH - 1 < int'(`FIFO_OFFSET_MAX) ||
		WIDTH + 1 != `FIFO_OFFSET_W) begin : g_bad_size
		$error("dual_clock_fifo: unsupported DEPTH or WIDTH");
	end

	logic [1:0] rst_sync_q;
	logic rst_q;
	logic wclk_q;
	logic rclk_q;
	logic wr_edge;
	logic rd_edge;
	logic prog_edge;
	logic do_write;
	logic do_read;
	logic [PW-1:0] wptr_q;
	logic [PW-1:0] rptr_q;
	logic [PW-1:0] cnt;
	logic [AW-1:0] rd_addr;
	fifo_pkg::prog_state_t prog_q;
	fifo_pkg::offset_t x_q;
	fifo_pkg::offset_t y_q;
	fifo_pkg::offset_t offset_in;
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_q = rst_sync_q[1];

	always_ff @(posedge clk or negedge rst_q) begin
		if (!rst_q) begin
			wclk_q <= 1'b1;
			rclk_q <= 1'b1;
		end else begin
			wclk_q <= write_clock;
			rclk_q <= read_clock;
		end
	end

	// The strobes start as if high so a pin already high at release is no edge.
	assign wr_edge = write_clock & ~wclk_q;
	assign rd_edge = read_clock & ~rclk_q;
	assign offset_in = {offset_msb_input, write_data_in};
	// Program enable low while the window is open turns the edge into a
	// programming edge and never a write; after the first word it is ignored.
	assign prog_edge = wr_edge & ~threshold_program_enable_n &
		(prog_q != fifo_pkg::PROG_CLOSED);
	assign cnt = wptr_q - rptr_q;
	assign do_write = wr_edge & ~prog_edge & (cnt != DEPTH_C);
	assign do_read = rd_edge & (cnt != '0);

	always_ff @(posedge clk or negedge rst_q) begin
		if (!rst_q) begin
			prog_q <= fifo_pkg::PROG_OPEN;
		end else if (prog_edge) begin
			case (prog_q)
				fifo_pkg::PROG_OPEN: prog_q <= fifo_pkg::PROG_SECOND;
				default: prog_q <= fifo_pkg::PROG_CLOSED;
			endcase
		end else if (wr_edge) begin
			prog_q <= fifo_pkg::PROG_CLOSED;
		end
	end

	always_ff @(posedge clk or negedge rst_q) begin
		if (!rst_q) begin
			x_q <= `FIFO_OFFSET_DEFAULT;
		end else if (prog_edge && prog_q == fifo_pkg::PROG_OPEN) begin
			x_q <= offset_in;
		end
	end

	always_ff @(posedge clk or negedge rst_q) begin
		if (!rst_q) begin
			y_q <= `FIFO_OFFSET_DEFAULT;
		end else if (prog_edge) begin
			y_q <= offset_in;
		end
	end

	// Both pointers live in clk, so the flags need no cross-domain resync.
	always_ff @(posedge clk or negedge rst_q) begin
		if (!rst_q) begin
			wptr_q <= '0;
		end else if (do_write) begin
			wptr_q <= wptr_q + PW'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_q) begin
		if (!rst_q) begin
			rptr_q <= '0;
		end else if (do_read) begin
			rptr_q <= rptr_q + PW'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (do_write) begin
			mem[wptr_q[AW-1:0]] <= write_data_in;
		end
	end

	// The output register always holds the word at the head, so the first
	// word shows without a read; a write into the head slot is bypassed.
	assign rd_addr = do_read ? rptr_q[AW-1:0] + AW'(1) : rptr_q[AW-1:0];

	always_ff @(posedge clk or negedge rst_q) begin
		if (!rst_q) begin
			read_data_out <= '0;
		end else if (do_write && wptr_q[AW-1:0] == rd_addr) begin
			read_data_out <= write_data_in;
		end else begin
			read_data_out <= mem[rd_addr];
		end
	end

	assign read_data_oe = output_enable;

	// Flags come straight from the registered pointers and thresholds.
	assign empty_n = (cnt != '0);
	assign full_n = (cnt != DEPTH_C);
	assign half_level_flag = (cnt >= HALF_C);
	assign near_limit_flag = (cnt <= PW'(x_q)) ||
		(cnt >= DEPTH_C - PW'(y_q));

	// Cascade pins are board wiring only; a lone device passes the token on.
	assign chain_token_out = chain_token_in & chain_mode_select &
		~chain_head_select;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_q);

	sequence seq_first_prog;
		prog_edge && prog_q == fifo_pkg::PROG_OPEN;
	endsequence

	// A strobe needs a low and a high clk period, so the next programming
	// edge comes two or more cycles later; the window then closes.
	sequence seq_second_prog;
		seq_first_prog ##[2:8]
			(prog_edge && prog_q == fifo_pkg::PROG_SECOND);
	endsequence

	chk_empty_flag: assert property (empty_n != (wptr_q == rptr_q))
		else $error("empty flag disagrees with pointers");
	chk_full_flag: assert property (!full_n ==
		(wptr_q[AW] != rptr_q[AW] && wptr_q[AW-1:0] == rptr_q[AW-1:0]))
		else $error("full flag disagrees with pointers");
	chk_half_level: assert property (
		half_level_flag == (cnt > PW'(1023)))
		else $error("half flag wrong");
	chk_near_limit: assert property (
		near_limit_flag == (cnt <= PW'(x_q) || cnt + PW'(y_q) >= DEPTH_C))
		else $error("near flag disagrees with the limit bands");
	chk_no_write_full: assert property (!full_n |=> $stable(wptr_q))
		else $error("write taken while full");
	chk_no_read_empty: assert property (!empty_n |=> $stable(rptr_q))
		else $error("read taken while empty");
	chk_prog_first_load: assert property (seq_first_prog |=>
		x_q == $past(offset_in) && y_q == $past(offset_in))
		else $error("first programming edge did not load both offsets");
	chk_prog_second_load: assert property (seq_second_prog |=>
		x_q == $past(x_q) && y_q == $past(offset_in))
		else $error("second programming edge disturbed X or missed Y");
	chk_prog_no_store: assert property (prog_edge |=> $stable(wptr_q))
		else $error("data stored on a programming edge");
	chk_default_thresh: assert property (
		prog_q == fifo_pkg::PROG_OPEN |->
		x_q == `FIFO_OFFSET_DEFAULT && y_q == `FIFO_OFFSET_DEFAULT)
		else $error("thresholds not at default before programming");
	chk_fall_through: assert property (
		do_write && cnt == '0 |=>
		empty_n && read_data_out == $past(write_data_in))
		else $error("first word did not fall through");
	chk_oe_follow: assert property (read_data_oe == output_enable)
		else $error("output enable not followed");

endmodule
`default_nettype wire

// File: verif/fifo_host_model.sv
/*
 * Writing and reading system logic beside the FIFO, sharing its clock.
 * Assumes its tasks are called from the falling edge of clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fifo_cfg.svh"
module fifo_host_model (
	input wire logic clk,
	input wire logic [`FIFO_WIDTH-1:0] read_data_out,
	input wire logic read_data_oe,
	output logic write_clock,
	output logic read_clock,
	output logic [`FIFO_WIDTH-1:0] write_data_in,
	output logic offset_msb_input,
	output logic threshold_program_enable_n,
	output wire logic [`FIFO_WIDTH-1:0] board_q
);
	// The board wire has no pull, so a released bus reads as floating.
	assign board_q = read_data_oe ? read_data_out : 'z;
	initial begin
		write_clock = 1'b0;
		read_clock = 1'b0;
		{offset_msb_input, write_data_in} = '0;
		threshold_program_enable_n = 1'b1;
	end
	// Enable and value move only while the strobe is low.
	task automatic load(input fifo_pkg::offset_t v, input logic pen_n);
		{offset_msb_input, write_data_in} = v;
		threshold_program_enable_n = pen_n;
		@(negedge clk) write_clock = 1'b1;
		@(negedge clk) write_clock = 1'b0;
		@(negedge clk);
	endtask
	task automatic unload;
		read_clock = 1'b1;
		@(negedge clk) read_clock = 1'b0;
		@(negedge clk);
	endtask
endmodule
`default_nettype wire

// File: verif/dual_clock_fifo_2048x9_test.sv
/*
 * Self-checking bench of the 2048 x 9 FIFO driven through a host model.
 * Assumes the design, its package and the host model compile first.
 */
`timescale 1ns/1ps
`default_nettype none
module dual_clock_fifo_2048x9_test;
	logic clk;
	logic rst_n;
	logic output_enable;
	wire logic write_clock;
	wire logic read_clock;
	wire logic [8:0] write_data_in;
	wire logic offset_msb_input;
	wire logic threshold_program_enable_n;
	wire logic [8:0] read_data_out;
	wire logic read_data_oe;
	wire logic [8:0] board_q;
	wire logic full_n;
	wire logic empty_n;
	wire logic half_level_flag;
	wire logic near_limit_flag;
	wire logic chain_token_out;
	logic chain_token;
	int num_errors = 0;
	int checks = 0;
	int x_lim = 256;
	int y_lim = 256;
	logic [8:0] stored[$];

	dual_clock_fifo uut (
		.clk, .rst_n, .write_clock, .read_clock, .write_data_in,
		.offset_msb_input, .threshold_program_enable_n, .output_enable,
		.chain_mode_select(1'b1),
		.chain_head_select(1'b0),
		.chain_token_in(chain_token),
		.chain_token_out, .read_data_out, .read_data_oe, .full_n,
		.empty_n, .half_level_flag, .near_limit_flag
	);
	fifo_host_model host (
		.clk, .read_data_out, .read_data_oe, .write_clock, .read_clock,
		.write_data_in, .offset_msb_input, .threshold_program_enable_n,
		.board_q
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic cmp_word(input logic [8:0] got, input logic [8:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_flags(input logic [3:0] got, input logic [3:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Flags are predicted from the bench's own word count.
	task automatic check_flags;
		int n;
		logic [3:0] exp;
		logic [3:0] got;
		n = stored.size();
		exp = {n != 2048, n != 0, n >= 1024, n <= x_lim || n >= 2048 - y_lim};
		got = {full_n, empty_n, half_level_flag, near_limit_flag};
		cmp_flags(got, exp);
	endtask
	task automatic put(input logic [8:0] d, input logic pen_n);
		host.load({1'b0, d}, pen_n);
		if (stored.size() < 2048) stored.push_back(d);
		check_flags();
	endtask
	task automatic take;
		if (stored.size() > 0) cmp_word(board_q, stored[0]);
		host.unload();
		if (stored.size() > 0) void'(stored.pop_front());
		check_flags();
	endtask
	task automatic reset_seq;
		rst_n = 1'b0;
		stored.delete();
		x_lim = 256;
		y_lim = 256;
		repeat (20) @(negedge clk);
		check_flags();
		cmp_bit(chain_token_out, 1'b0);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
	endtask
	// Overfill by one, float the outputs, then drain to the half mark.
	task automatic run_default;
		for (int i = 0; i < 2049; i++) begin
			put(9'(i) ^ 9'h0A5, 1'b1);
		end
		output_enable = 1'b0;
		@(negedge clk);
		cmp_word(board_q, 'z);
		check_flags();
		output_enable = 1'b1;
		// A lone device hands the chain token straight on.
		chain_token = 1'b1;
		@(negedge clk);
		cmp_bit(chain_token_out, 1'b1);
		chain_token = 1'b0;
		repeat (1024) take();
	endtask
	// Reset lands with words stored, so stale pointers would show.
	task automatic run_program;
		reset_seq();
		host.load(10'h2A5, 1'b0);
		x_lim = 677;
		y_lim = 677;
		check_flags();
		host.load(10'h00F, 1'b0);
		y_lim = 15;
		check_flags();
		put(9'h1C3, 1'b1);
		put(9'h03C, 1'b0);
		for (int i = 2; i < 2049; i++) put(9'(i), 1'b1);
		repeat (2049) take();
	endtask

	task automatic tally_and_finish;
		$display("checks=%0d num_errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		rst_n = 1'b0;
		output_enable = 1'b1;
		chain_token = 1'b0;
		reset_seq();
		run_default();
		run_program();
		tally_and_finish();
	end
	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
